// ===== design/rxc_params.svh
// Register offsets, field positions and reset values of the receiver config slice.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef RXC_PARAMS_SVH
`define RXC_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RXC_OFS_STATUS 5'h0e
`define RXC_OFS_THRESH 5'h0f
`define RXC_OFS_BW 5'h10
`define RXC_OFS_IMAGE 5'h11
`define RXC_OFS_SYNC 5'h12
`define RXC_OFS_IRQ_STAT 5'h1e
`define RXC_OFS_IRQ_MASK 5'h1f

// ----------------------------------------
// Field positions of the status register
// ----------------------------------------
`define RXC_B_FILL_POLICY 7
`define RXC_B_FILL_CTRL 6
`define RXC_B_LEVEL 2
`define RXC_B_LOCK 1
`define RXC_B_LOCK_EN 0

// ----------------------------------------
// Field positions of the sync config register
// ----------------------------------------
`define RXC_B_IMG_EN 7
`define RXC_B_BITSYNC_OFF 6
`define RXC_B_SYNC_EN 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RXC_RST_RES14 2'h0
`define RXC_RST_THRESH 8'h00
`define RXC_RST_PREFILT 4'h0
`define RXC_RST_CHAN 4'h3
`define RXC_RST_CENTER 4'h3
`define RXC_RST_RES17 4'h8
`define RXC_RST_SYNC_LEN 2'h3
`define RXC_RST_SYNC_TOL 2'h0
`define RXC_RST_MASK 2'h0

// Interrupt status bit positions
`define RXC_IRQ_LEVEL 0
`define RXC_IRQ_LOCK 1

`endif

// ===== design/rxc_pkg.sv
// Types shared by the receiver config slice.
// Assumes rxc_params.svh supplies the numbers.
package rxc_pkg;
    // Sync pattern length selection
    typedef enum logic [1:0] {
        RXC_SYNC_8,
        RXC_SYNC_16,
        RXC_SYNC_24,
        RXC_SYNC_32
    } rxc_sync_len_t;
    // Capture state of the FIFO load gate
    typedef enum logic {
        RXC_IDLE,
        RXC_LOAD
    } rxc_cap_state_t;
endpackage

// ===== design/rxc_sticky.sv
// One sticky flag: hardware set beats a write-one clear in the same cycle.
// Assumes single clock, synchronous active-high reset.
`timescale 1ns/1ps
module rxc_sticky (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic set_in,
    input wire logic clr_in,
    output logic flag_reg
);
    // ----------------------------------------
    // Flag storage
    // ----------------------------------------
    // Set is tested first so a coincident event is not lost
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else if (set_in) begin
            flag_reg <= 1'b1;
        end else if (clr_in) begin
            flag_reg <= 1'b0;
        end
    end
endmodule

// ===== design/rxc_regs.sv
// Receiver interrupt and configuration registers, addresses 14 to 18, plus irq regs.
// Assumes a plain strobe port master and a synchronous level measurement input.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "rxc_params.svh"

module rxc_regs #(
    parameter int ADDR_W = 5,
    parameter int DATA_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rdata,
    input wire logic [7:0] signal_strength,
    input wire logic synth_lock_det,
    input wire logic sync_detected,
    input wire logic fifo_full_stop,
    output logic fifo_load_en,
    output logic lock_pin_o,
    output logic lock_pin_oe_n,
    output logic [3:0] prefilter_bw_code,
    output logic [3:0] channel_bw_code,
    output logic [3:0] image_filter_center_code,
    output logic image_filter_enable,
    output logic bitsync_run,
    output logic sync_enable,
    output logic [1:0] sync_len_code,
    output logic [1:0] sync_tol_code,
    output logic irq
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic fill_policy_reg; // 1: manual capture
    logic fill_ctrl_reg; // Manual capture control bit
    logic [1:0] res14_reg; // Reserved bits 4-3
    logic lock_en_reg; // Lock pin enable
    logic [7:0] thresh_reg; // Level alarm threshold
    logic [3:0] prefilt_reg; // Prefilter code
    logic [3:0] chan_reg; // Channel bandwidth code
    logic [3:0] center_reg; // Image center code
    logic [3:0] res17_reg; // Reserved bits 3-0
    logic img_en_reg; // Image filter enable
    logic bitsync_off_reg; // Bit recovery bypass
    logic sync_en_reg; // Sync recognition enable
    logic [1:0] sync_len_reg; // Pattern length code
    logic [1:0] sync_tol_reg; // Error allowance code
    logic res18_reg; // Reserved bit 0
    logic [1:0] irq_mask_reg; // Interrupt mask
    logic [1:0] irq_stat_reg; // Interrupt status
    logic level_flag; // Signal-level flag
    logic lock_flag; // Synth lock flag
    logic lock_prev_reg; // Lock edge detect
    logic level_prev_reg; // Level edge detect
    rxc_pkg::rxc_cap_state_t cap_state_reg; // Auto capture state

    // Address hit helper, used for every register
    function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        wr_hit = wr_stb && (a == ofs);
    endfunction

    logic level_above; // Strength above threshold
    logic lock_set; // Lock flag set pulse
    logic level_clr; // Write one to level bit
    logic lock_clr; // Write one to lock bit
    logic wr_status; // Status register write

    assign wr_status = wr_hit(addr, `RXC_OFS_STATUS);
    assign level_above = signal_strength > thresh_reg;
    assign level_clr = wr_status && wdata[`RXC_B_LEVEL];
    assign lock_clr = wr_status && wdata[`RXC_B_LOCK];
    // Lock detection is disabled while its enable is zero
    assign lock_set = synth_lock_det && lock_en_reg && !lock_prev_reg;

    // ----------------------------------------
    // Sticky flags
    // ----------------------------------------
    rxc_sticky u_level (
        .core_clk(core_clk),
        .rst(rst),
        .set_in(level_above),
        .clr_in(level_clr),
        .flag_reg(level_flag)
    );

    rxc_sticky u_lock (
        .core_clk(core_clk),
        .rst(rst),
        .set_in(lock_set),
        .clr_in(lock_clr),
        .flag_reg(lock_flag)
    );

    // Edge memory so a steady lock does not re-set a cleared flag forever
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lock_prev_reg <= 1'b0;
            level_prev_reg <= 1'b0;
        end else begin
            lock_prev_reg <= synth_lock_det && lock_en_reg;
            level_prev_reg <= level_flag;
        end
    end

    // ----------------------------------------
    // Status register 14 control fields
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fill_policy_reg <= 1'b0;
            fill_ctrl_reg <= 1'b0;
            res14_reg <= `RXC_RST_RES14;
            lock_en_reg <= 1'b1;
        end else if (wr_status) begin
            fill_policy_reg <= wdata[`RXC_B_FILL_POLICY];
            fill_ctrl_reg <= wdata[`RXC_B_FILL_CTRL];
            res14_reg <= wdata[4:3];
            lock_en_reg <= wdata[`RXC_B_LOCK_EN];
        end
    end

    // ----------------------------------------
    // Configuration registers 15 to 18
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            thresh_reg <= `RXC_RST_THRESH;
            prefilt_reg <= `RXC_RST_PREFILT;
            chan_reg <= `RXC_RST_CHAN;
            center_reg <= `RXC_RST_CENTER;
            res17_reg <= `RXC_RST_RES17;
            img_en_reg <= 1'b0;
            bitsync_off_reg <= 1'b0;
            sync_en_reg <= 1'b0;
            sync_len_reg <= `RXC_RST_SYNC_LEN;
            sync_tol_reg <= `RXC_RST_SYNC_TOL;
            res18_reg <= 1'b0;
        end else begin
            if (wr_hit(addr, `RXC_OFS_THRESH)) begin
                thresh_reg <= wdata;
            end
            if (wr_hit(addr, `RXC_OFS_BW)) begin
                prefilt_reg <= wdata[7:4];
                chan_reg <= wdata[3:0];
            end
            if (wr_hit(addr, `RXC_OFS_IMAGE)) begin
                center_reg <= wdata[7:4];
                res17_reg <= wdata[3:0];
            end
            if (wr_hit(addr, `RXC_OFS_SYNC)) begin
                img_en_reg <= wdata[`RXC_B_IMG_EN];
                bitsync_off_reg <= wdata[`RXC_B_BITSYNC_OFF];
                sync_en_reg <= wdata[`RXC_B_SYNC_EN];
                sync_len_reg <= wdata[4:3];
                sync_tol_reg <= wdata[2:1];
                res18_reg <= wdata[0];
            end
        end
    end

    // ----------------------------------------
    // Configuration outputs, one cycle after the write
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prefilter_bw_code <= `RXC_RST_PREFILT;
            channel_bw_code <= `RXC_RST_CHAN;
            image_filter_center_code <= `RXC_RST_CENTER;
            image_filter_enable <= 1'b0;
            bitsync_run <= 1'b1;
            sync_enable <= 1'b0;
            sync_len_code <= `RXC_RST_SYNC_LEN;
            sync_tol_code <= `RXC_RST_SYNC_TOL;
        end else begin
            prefilter_bw_code <= prefilt_reg;
            channel_bw_code <= chan_reg;
            image_filter_center_code <= center_reg;
            image_filter_enable <= img_en_reg;
            bitsync_run <= !bitsync_off_reg;
            sync_enable <= sync_en_reg;
            sync_len_code <= sync_len_reg;
            sync_tol_code <= sync_tol_reg;
        end
    end

    // ----------------------------------------
    // Lock pin
    // ----------------------------------------
    // Enable low while driving; pin floats when lock detection is off
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lock_pin_o <= 1'b0;
            lock_pin_oe_n <= 1'b1;
        end else begin
            lock_pin_o <= lock_flag && lock_en_reg;
            lock_pin_oe_n <= !lock_en_reg;
        end
    end

    // ----------------------------------------
    // Automatic capture state
    // ----------------------------------------
    // Waits for sync, loads until full stops it or policy turns manual
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cap_state_reg <= rxc_pkg::RXC_IDLE;
        end else begin
            unique case (cap_state_reg)
                rxc_pkg::RXC_IDLE: begin
                    if (!fill_policy_reg && sync_detected) begin
                        cap_state_reg <= rxc_pkg::RXC_LOAD;
                    end
                end
                rxc_pkg::RXC_LOAD: begin
                    if (fill_policy_reg || fifo_full_stop) begin
                        cap_state_reg <= rxc_pkg::RXC_IDLE;
                    end
                end
            endcase
        end
    end

    // Load gate: manual bit or auto state, by policy
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fifo_load_en <= 1'b0;
        end else if (fill_policy_reg) begin
            fifo_load_en <= fill_ctrl_reg;
        end else begin
            fifo_load_en <= (cap_state_reg == rxc_pkg::RXC_LOAD);
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    // Level flag rising edge and the lock set pulse set sticky bits; write one clears, set wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_stat_reg <= 2'h0;
            irq_mask_reg <= `RXC_RST_MASK;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (i == `RXC_IRQ_LEVEL && level_flag && !level_prev_reg) begin
                    irq_stat_reg[i] <= 1'b1;
                end else if (i == `RXC_IRQ_LOCK && lock_set) begin
                    irq_stat_reg[i] <= 1'b1;
                end else if (wr_hit(addr, `RXC_OFS_IRQ_STAT) && wdata[i]) begin
                    irq_stat_reg[i] <= 1'b0;
                end
            end
            if (wr_hit(addr, `RXC_OFS_IRQ_MASK)) begin
                irq_mask_reg <= wdata[1:0];
            end
        end
    end

    // Registered interrupt level, one cycle behind status
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Data stand only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= '0;
        end else if (rd_stb) begin
            unique case (addr)
                `RXC_OFS_STATUS: rdata <= {fill_policy_reg, fill_ctrl_reg, 1'b0, res14_reg,
                    level_flag, lock_flag, lock_en_reg};
                `RXC_OFS_THRESH: rdata <= thresh_reg;
                `RXC_OFS_BW: rdata <= {prefilt_reg, chan_reg};
                `RXC_OFS_IMAGE: rdata <= {center_reg, res17_reg};
                `RXC_OFS_SYNC: rdata <= {img_en_reg, bitsync_off_reg, sync_en_reg, sync_len_reg,
                    sync_tol_reg, res18_reg};
                `RXC_OFS_IRQ_STAT: rdata <= {6'h00, irq_stat_reg};
                `RXC_OFS_IRQ_MASK: rdata <= {6'h00, irq_mask_reg};
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_level_set;
        @(posedge core_clk) disable iff (rst) level_above |=> level_flag;
    endproperty
    a_level_set: assert property (p_level_set) else $error("level flag not set");

    property p_level_clr;
        @(posedge core_clk) disable iff (rst) level_clr && !level_above |=> !level_flag;
    endproperty
    a_level_clr: assert property (p_level_clr) else $error("level flag not cleared");

    property p_lock_clr;
        @(posedge core_clk) disable iff (rst) lock_clr && !lock_set |=> !lock_flag;
    endproperty
    a_lock_clr: assert property (p_lock_clr) else $error("lock flag not cleared");

    property p_pin_float;
        @(posedge core_clk) disable iff (rst) !lock_en_reg |=> lock_pin_oe_n;
    endproperty
    a_pin_float: assert property (p_pin_float) else $error("lock pin driven while disabled");

    sequence s_manual_on;
        fill_policy_reg && fill_ctrl_reg;
    endsequence
    property p_manual;
        @(posedge core_clk) disable iff (rst) s_manual_on |=> fifo_load_en;
    endproperty
    a_manual: assert property (p_manual) else $error("manual capture ignored");

    property p_auto;
        @(posedge core_clk) disable iff (rst)
            cap_state_reg == rxc_pkg::RXC_IDLE && !fill_policy_reg && sync_detected |=> ##1 fifo_load_en;
    endproperty
    a_auto: assert property (p_auto) else $error("sync did not start loading");

    property p_bw_follow;
        @(posedge core_clk) disable iff (rst)
            wr_stb && addr == `RXC_OFS_BW |=> ##1 channel_bw_code == $past(wdata[3:0], 2);
    endproperty
    a_bw_follow: assert property (p_bw_follow) else $error("channel code not applied");

    property p_sync_follow;
        @(posedge core_clk) disable iff (rst)
            wr_stb && addr == `RXC_OFS_SYNC |=> ##1 sync_len_code == $past(wdata[4:3], 2)
                && bitsync_run == !$past(wdata[6], 2);
    endproperty
    a_sync_follow: assert property (p_sync_follow) else $error("sync config not applied");
endmodule

// ===== tb/rxc_regs_test.sv
// Self-checking bench for the receiver config slice: bus, flags, irq, capture gate.
// Assumes the design files under design/ are compiled first; one 250 MHz clock.
`timescale 1ns/1ps
`include "rxc_params.svh"
module rxc_regs_test;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic core_clk = 1'b0; // 4 ns period
    logic rst = 1'b1; // Synchronous, active high
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rdata;
    logic [7:0] signal_strength = 8'h00;
    logic synth_lock_det = 1'b0; // Low through reset so no lock edge appears early
    logic sync_detected = 1'b0;
    logic fifo_full_stop = 1'b0;
    logic fifo_load_en, lock_pin_o, lock_pin_oe_n, image_filter_enable, bitsync_run, sync_enable, irq;
    logic [3:0] prefilter_bw_code, channel_bw_code, image_filter_center_code;
    logic [1:0] sync_len_code, sync_tol_code;
    int miscompares = 0; // Mismatch count
    int checked = 0; // Comparison count

    always #2 core_clk = ~core_clk;

    rxc_regs dut_u (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .signal_strength(signal_strength), .synth_lock_det(synth_lock_det),
        .sync_detected(sync_detected), .fifo_full_stop(fifo_full_stop), .fifo_load_en(fifo_load_en),
        .lock_pin_o(lock_pin_o), .lock_pin_oe_n(lock_pin_oe_n), .prefilter_bw_code(prefilter_bw_code),
        .channel_bw_code(channel_bw_code), .image_filter_center_code(image_filter_center_code),
        .image_filter_enable(image_filter_enable), .bitsync_run(bitsync_run), .sync_enable(sync_enable),
        .sync_len_code(sync_len_code), .sync_tol_code(sync_tol_code), .irq(irq));

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    // Wait n edges, then step past the edge so updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One comparison, case equality so unknowns fail
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe; returns at the taking edge
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask

    // One-cycle read strobe; data stands only in the following cycle
    task automatic rd_chk(input string what, input logic [4:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    // Single-cycle pulse on a side input
    task automatic pulse_sync();
        @(posedge core_clk);
        sync_detected <= 1'b1;
        @(posedge core_clk);
        sync_detected <= 1'b0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset values of registers 14 to 18 and of every config output
    task automatic t_reset();
        rd_chk("status", `RXC_OFS_STATUS, 8'h01);
        rd_chk("thresh", `RXC_OFS_THRESH, 8'h00);
        rd_chk("bw", `RXC_OFS_BW, 8'h03);
        rd_chk("image", `RXC_OFS_IMAGE, 8'h38);
        rd_chk("sync", `RXC_OFS_SYNC, 8'h18);
        chk("codes", 8'h03, {prefilter_bw_code, channel_bw_code});
        chk("center", 8'h03, {4'h0, image_filter_center_code});
        chk("syncout", 8'h2c, {1'b0, image_filter_enable, bitsync_run, sync_enable,
            sync_len_code, sync_tol_code});
        chk("misc", 8'h00, {5'h00, fifo_load_en, lock_pin_oe_n, irq});
    endtask

    // Config write lands on outputs a cycle after the taking edge
    task automatic t_config();
        wr(`RXC_OFS_BW, 8'h5a);
        tick(1);
        chk("codes", 8'h5a, {prefilter_bw_code, channel_bw_code});
        wr(`RXC_OFS_IMAGE, 8'ha5);
        tick(1);
        chk("center", 8'h0a, {4'h0, image_filter_center_code});
        rd_chk("bw", `RXC_OFS_BW, 8'h5a);
        rd_chk("image", `RXC_OFS_IMAGE, 8'ha5);
        // Every length code, each paired with tolerance code three minus it
        for (int i = 0; i < 4; i++) begin
            wr(`RXC_OFS_SYNC, {3'b111, 2'(i), 2'(3 - i), 1'b1});
            tick(1);
            chk("syncout", {1'b0, 3'b101, 2'(i), 2'(3 - i)}, {1'b0, image_filter_enable, bitsync_run,
                sync_enable, sync_len_code, sync_tol_code});
            rd_chk("sync", `RXC_OFS_SYNC, {3'b111, 2'(i), 2'(3 - i), 1'b1});
        end
        wr(`RXC_OFS_SYNC, 8'h18);
        tick(1);
        chk("syncoff", 8'h2c, {1'b0, image_filter_enable, bitsync_run, sync_enable,
            sync_len_code, sync_tol_code});
        // Unmapped place reads zero and ignores writes
        wr(5'h05, 8'hff);
        rd_chk("unmapped", 5'h05, 8'h00);
    endtask

    // Level flag at the threshold boundary, W1C, irq masking
    task automatic t_level();
        wr(`RXC_OFS_THRESH, 8'h80);
        rd_chk("thresh", `RXC_OFS_THRESH, 8'h80);
        @(posedge core_clk);
        signal_strength <= 8'h80;
        tick(3);
        rd_chk("equal", `RXC_OFS_STATUS, 8'h01);
        @(posedge core_clk);
        signal_strength <= 8'h81;
        tick(3);
        @(posedge core_clk);
        signal_strength <= 8'h00;
        rd_chk("above", `RXC_OFS_STATUS, 8'h05);
        chk("irq_masked", 8'h00, {7'h00, irq});
        wr(`RXC_OFS_IRQ_MASK, 8'h03);
        tick(2);
        chk("irq_on", 8'h01, {7'h00, irq});
        wr(`RXC_OFS_STATUS, 8'h01);
        rd_chk("w0keep", `RXC_OFS_STATUS, 8'h05);
        wr(`RXC_OFS_STATUS, 8'h05);
        rd_chk("w1clr", `RXC_OFS_STATUS, 8'h01);
        rd_chk("irq_stat", `RXC_OFS_IRQ_STAT, 8'h01);
        wr(`RXC_OFS_IRQ_STAT, 8'h01);
        tick(2);
        chk("irq_off", 8'h00, {7'h00, irq});
    endtask

    // Lock flag, its clear, and the lock pin enable
    task automatic t_lock();
        @(posedge core_clk);
        synth_lock_det <= 1'b1;
        tick(3);
        rd_chk("locked", `RXC_OFS_STATUS, 8'h03);
        chk("pin", 8'h02, {6'h00, lock_pin_o, lock_pin_oe_n});
        chk("irq_lock", 8'h01, {7'h00, irq});
        wr(`RXC_OFS_STATUS, 8'h03);
        tick(2);
        rd_chk("lockclr", `RXC_OFS_STATUS, 8'h01);
        wr(`RXC_OFS_IRQ_STAT, 8'h02);
        wr(`RXC_OFS_STATUS, 8'h00);
        tick(2);
        chk("pin_off", 8'h01, {6'h00, lock_pin_o, lock_pin_oe_n});
        chk("irq_clr", 8'h00, {7'h00, irq});
        @(posedge core_clk);
        synth_lock_det <= 1'b0;
        wr(`RXC_OFS_STATUS, 8'h01);
    endtask

    // Automatic and manual FIFO capture gate
    task automatic t_capture();
        pulse_sync();
        tick(2);
        chk("auto_on", 8'h01, {7'h00, fifo_load_en});
        @(posedge core_clk);
        fifo_full_stop <= 1'b1;
        @(posedge core_clk);
        fifo_full_stop <= 1'b0;
        tick(2);
        chk("auto_off", 8'h00, {7'h00, fifo_load_en});
        wr(`RXC_OFS_STATUS, 8'he1);
        tick(1);
        chk("man_on", 8'h01, {7'h00, fifo_load_en});
        rd_chk("ro_bit5", `RXC_OFS_STATUS, 8'hc1);
        wr(`RXC_OFS_STATUS, 8'h81);
        tick(1);
        chk("man_off", 8'h00, {7'h00, fifo_load_en});
        pulse_sync();
        tick(2);
        chk("man_nosync", 8'h00, {7'h00, fifo_load_en});
        wr(`RXC_OFS_STATUS, 8'h01);
    endtask

    // ----------------------------------------
    // Verdict, the one place the run ends
    // ----------------------------------------
    task automatic finish_test();
        $display("miscompares %0d checked %0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #(20000 * 4);
        miscompares++;
        finish_test();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        tick(1);
        t_reset();
        t_config();
        t_level();
        t_lock();
        t_capture();
        finish_test();
    end
endmodule
